// ==== design/pcgbt_defines.vh ====
// constants for the peripheral clock gate bank two block
`ifndef PCGBT_DEFINES_VH
`define PCGBT_DEFINES_VH

// register indices; byte address is four times the index
`define PCGBT_GATE_IDX 16'h1C03
`define PCGBT_STAT_IDX 16'h1C04
`define PCGBT_GATE_ADDR (`PCGBT_GATE_IDX << 2)
`define PCGBT_STAT_ADDR (`PCGBT_STAT_IDX << 2)

// gate register field positions
`define PCGBT_BIT_DISPLAY 0
`define PCGBT_BIT_CONVERTER 1
`define PCGBT_BIT_USB 2
`define PCGBT_BIT_DMA1 3
`define PCGBT_BIT_DMA2 4
`define PCGBT_BIT_DMA3 5
`define PCGBT_BIT_ANALOG 6
`define PCGBT_NUM_GATES 7
`define PCGBT_GATE_MASK 7'h7F
`define PCGBT_GATE_RESET 7'h00

// status register field positions
`define PCGBT_STAT_ACK 7
`define PCGBT_STAT_EARLY 8
`define PCGBT_STAT_W 9

// bus widths and answers
`define PCGBT_ADDR_W 16
`define PCGBT_DATA_W 32
`define PCGBT_BE_W 4
`define PCGBT_RESP_OKAY 2'h0
`define PCGBT_RESP_SLVERR 2'h2
`define PCGBT_DATA_ZERO 32'h00000000

`endif

// ==== design/pcgbt_run_chan.v ====
// one clock run-enable channel: gate bit plus keep-running override
`include "pcgbt_defines.vh"

module pcgbt_run_chan (
  // clock and reset
  input wire clock,
  input wire rstn,
  // control
  input wire stop_gate,
  input wire keep_running,
  // result
  output reg run_q
);

  wire run_d;

  // gate 1 stops the clock, 0 lets it run; override forces run
  assign run_d = ~stop_gate | keep_running;

  // after reset every gated clock runs
  always @(posedge clock) begin
    if (!rstn) begin
      run_q <= 1'b1;
    end else begin
      run_q <= run_d;
    end
  end

endmodule // pcgbt_run_chan

// ==== design/pcgbt_regs.v ====
// gating register bank two with avalon-mm slave and run-enable outputs
`include "pcgbt_defines.vh"

// What this block does
// - bit 6 gates analog-domain register clock
// - converter gate 0 forces analog clock running
// - bit 5 gates third dma clock
// - bit 4 gates second dma clock
// - bit 3 gates first dma clock
// - bit 2 gates usb controller clock
// - usb gate leaves usb pll running
// - bit 1 gates converter clock
// - bit 0 gates display controller clock
module pcgbt_regs (
  // clock and reset
  input wire clock,
  input wire rstn,
  // avalon-mm slave
  input wire [`PCGBT_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [`PCGBT_DATA_W-1:0] avs_writedata,
  input wire [`PCGBT_BE_W-1:0] avs_byteenable,
  output reg [`PCGBT_DATA_W-1:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  // usb clock stop acknowledge, from the usb clock domain
  input wire usb_stop_ack,
  // clock run enables, high while the clock runs
  output wire display_controller_clk_run,
  output wire converter_clk_run,
  output wire usb_controller_clk_run,
  output wire first_dma_clk_run,
  output wire second_dma_clk_run,
  output wire third_dma_clk_run,
  output wire analog_register_clk_run,
  output reg usb_pll_run
);

  // gate register, only the seven live bits are stored
  reg [`PCGBT_NUM_GATES-1:0] gate_q;
  reg [`PCGBT_NUM_GATES-1:0] gate_d;

  // bus handshake state
  reg [`PCGBT_DATA_W-1:0] rdata_d;
  reg [1:0] resp_d;
  reg wait_d;
  reg [`PCGBT_DATA_W-1:0] read_image;

  // ack synchroniser and diagnostic flag
  reg ack_meta_q;
  reg ack_sync_q;
  reg early_stop_q;
  reg early_stop_d;

  // decode
  wire hit_gate;
  wire hit_stat;
  wire hit_any;
  wire req;
  wire accept;
  wire wr_accept;
  wire gate_wr;
  wire stat_wr;
  wire usb_rise;

  // run enables from the channel flops
  wire [`PCGBT_NUM_GATES-1:0] run_vec;
  wire [`PCGBT_NUM_GATES-1:0] keep_vec;

  // composed read images
  wire [`PCGBT_DATA_W-1:0] gate_image;
  wire [`PCGBT_DATA_W-1:0] stat_image;

  // gate fields by name
  wire analog_register_clock_gate;
  wire third_dma_clock_gate;
  wire second_dma_clock_gate;
  wire first_dma_clock_gate;
  wire usb_controller_clock_gate;
  wire converter_clock_gate;
  wire display_controller_clock_gate;

  // each stored bit is 1 to stop its clock, 0 to let it run
  assign analog_register_clock_gate = gate_q[`PCGBT_BIT_ANALOG];
  assign third_dma_clock_gate = gate_q[`PCGBT_BIT_DMA3];
  assign second_dma_clock_gate = gate_q[`PCGBT_BIT_DMA2];
  assign first_dma_clock_gate = gate_q[`PCGBT_BIT_DMA1];
  assign usb_controller_clock_gate = gate_q[`PCGBT_BIT_USB];
  assign converter_clock_gate = gate_q[`PCGBT_BIT_CONVERTER];
  assign display_controller_clock_gate = gate_q[`PCGBT_BIT_DISPLAY];

  assign hit_gate = (avs_address == `PCGBT_GATE_ADDR);
  assign hit_stat = (avs_address == `PCGBT_STAT_ADDR);
  assign hit_any = hit_gate | hit_stat;
  assign req = avs_read | avs_write;

  // a request is completed at the edge where waitrequest is seen low
  assign accept = req & ~avs_waitrequest;
  assign wr_accept = accept & avs_write;

  // all gate bits live in byte lane 0; lane 1 holds reserved bits only
  // a mapped write without its lane is dropped but still answered okay
  assign gate_wr = wr_accept & hit_gate & avs_byteenable[0];
  assign stat_wr = wr_accept & hit_stat & avs_byteenable[1];

  // reserved bits above the live field read as zero
  assign gate_image = {{(`PCGBT_DATA_W-`PCGBT_NUM_GATES){1'b0}}, gate_q};

  assign stat_image = {{(`PCGBT_DATA_W-`PCGBT_STAT_W){1'b0}}, early_stop_q, ack_sync_q, run_vec};

  // usb gate going from run to stop by this write
  assign usb_rise = gate_wr & avs_writedata[`PCGBT_BIT_USB] & ~gate_q[`PCGBT_BIT_USB];

  // ------------------------------------------------------------------
  // gate register
  // ------------------------------------------------------------------
  always @* begin
    gate_d = gate_q;
    if (gate_wr) begin
      // reserved bits are dropped by the slice to the seven live bits; the mask keeps all seven
      gate_d = avs_writedata[`PCGBT_NUM_GATES-1:0] & `PCGBT_GATE_MASK;
    end
  end

  // gates reset to zero so every clock runs out of reset
  always @(posedge clock) begin
    if (!rstn) begin
      gate_q <= `PCGBT_GATE_RESET;
    end else begin
      gate_q <= gate_d;
    end
  end

  // ------------------------------------------------------------------
  // usb stop acknowledge: two flops before any use
  // ------------------------------------------------------------------
  // ack comes from the usb domain; only the second flop is read
  always @(posedge clock) begin
    if (!rstn) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= usb_stop_ack;
      ack_sync_q <= ack_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // early stop flag: usb gate set while no acknowledge was seen.
  // hardware does not block the write, software owns the handshake;
  // the flag only lets a driver bug be seen. set wins over clear.
  // ------------------------------------------------------------------
  always @* begin
    early_stop_d = early_stop_q;
    if (stat_wr && avs_writedata[`PCGBT_STAT_EARLY]) begin
      early_stop_d = 1'b0;
    end
    if (usb_rise && !ack_sync_q) begin
      early_stop_d = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      early_stop_q <= 1'b0;
    end else begin
      early_stop_q <= early_stop_d;
    end
  end

  // ------------------------------------------------------------------
  // read image of the addressed register; unmapped reads give zero
  // ------------------------------------------------------------------
  always @* begin
    read_image = `PCGBT_DATA_ZERO;
    if (hit_gate) begin
      read_image = gate_image;
    end else if (hit_stat) begin
      read_image = stat_image;
    end
  end

  // ------------------------------------------------------------------
  // avalon handshake: one wait cycle, then a single low cycle
  // ------------------------------------------------------------------
  always @* begin
    wait_d = 1'b1;
    rdata_d = avs_readdata;
    resp_d = avs_response;
    if (req && avs_waitrequest) begin
      // answer is prepared at the same edge where the request is first seen
      wait_d = 1'b0;
      resp_d = hit_any ? `PCGBT_RESP_OKAY : `PCGBT_RESP_SLVERR;
      if (avs_read) begin
        rdata_d = read_image;
      end else begin
        rdata_d = `PCGBT_DATA_ZERO;
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `PCGBT_DATA_ZERO;
      avs_response <= `PCGBT_RESP_OKAY;
    end else begin
      avs_waitrequest <= wait_d;
      avs_readdata <= rdata_d;
      avs_response <= resp_d;
    end
  end

  // ------------------------------------------------------------------
  // run-enable channels
  // ------------------------------------------------------------------
  // analog registers keep their clock while the converter clock runs
  assign keep_vec = {~converter_clock_gate, {(`PCGBT_NUM_GATES-1){1'b0}}};

  // enables are flopped so a downstream gate cell never sees a decode glitch
  // display controller clock
  pcgbt_run_chan u_display_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(display_controller_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_DISPLAY]),
    .run_q(run_vec[`PCGBT_BIT_DISPLAY])
  );

  // converter clock
  pcgbt_run_chan u_converter_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(converter_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_CONVERTER]),
    .run_q(run_vec[`PCGBT_BIT_CONVERTER])
  );

  // usb controller clock; the usb pll is not touched from here
  pcgbt_run_chan u_usb_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(usb_controller_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_USB]),
    .run_q(run_vec[`PCGBT_BIT_USB])
  );

  // first dma controller clock
  pcgbt_run_chan u_first_dma_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(first_dma_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_DMA1]),
    .run_q(run_vec[`PCGBT_BIT_DMA1])
  );

  // second dma controller clock
  pcgbt_run_chan u_second_dma_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(second_dma_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_DMA2]),
    .run_q(run_vec[`PCGBT_BIT_DMA2])
  );

  // third dma controller clock
  pcgbt_run_chan u_third_dma_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(third_dma_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_DMA3]),
    .run_q(run_vec[`PCGBT_BIT_DMA3])
  );

  // analog-domain register clock, held on while the converter runs
  pcgbt_run_chan u_analog_chan (
    .clock(clock),
    .rstn(rstn),
    .stop_gate(analog_register_clock_gate),
    .keep_running(keep_vec[`PCGBT_BIT_ANALOG]),
    .run_q(run_vec[`PCGBT_BIT_ANALOG])
  );

  assign display_controller_clk_run = run_vec[`PCGBT_BIT_DISPLAY];
  assign converter_clk_run = run_vec[`PCGBT_BIT_CONVERTER];
  assign usb_controller_clk_run = run_vec[`PCGBT_BIT_USB];
  assign first_dma_clk_run = run_vec[`PCGBT_BIT_DMA1];
  assign second_dma_clk_run = run_vec[`PCGBT_BIT_DMA2];
  assign third_dma_clk_run = run_vec[`PCGBT_BIT_DMA3];
  assign analog_register_clk_run = run_vec[`PCGBT_BIT_ANALOG];

  // the pll enable never looks at the gate register
  // kept as a flop so every output of the block comes from a register
  always @(posedge clock) begin
    if (!rstn) begin
      usb_pll_run <= 1'b1;
    end else begin
      usb_pll_run <= 1'b1;
    end
  end

endmodule // pcgbt_regs

// ==== sim/pcgbt_chk.sv ====
// checks on gate bank two register ports
`include "pcgbt_defines.vh"
module pcgbt_chk (
  // clock and reset
  input logic clock,
  input logic rstn,
  // bus
  input logic [15:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [1:0] avs_response,
  input logic usb_stop_ack,
  // run enables
  input logic display_controller_clk_run,
  input logic converter_clk_run,
  input logic usb_controller_clk_run,
  input logic first_dma_clk_run,
  input logic second_dma_clk_run,
  input logic third_dma_clk_run,
  input logic analog_register_clk_run,
  input logic usb_pll_run
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire done = !avs_waitrequest && avs_address == `PCGBT_GATE_ADDR;
  wire wr = done && avs_write && avs_byteenable[0];
  wire [1:0] an = {avs_writedata[6], avs_writedata[1]};
  // run outputs lag the stored bit by one cycle
  property gp(run, i);
    wr |-> ##2 run == !$past(avs_writedata[i], 2);
  endproperty
  chk_display_gate: assert property (gp(display_controller_clk_run, 0)) else $error("display run");
  chk_conv_gate: assert property (gp(converter_clk_run, 1)) else $error("converter run");
  chk_usb_gate: assert property (gp(usb_controller_clk_run, 2)) else $error("usb run");
  chk_dma1_gate: assert property (gp(first_dma_clk_run, 3)) else $error("dma1 run");
  chk_dma2_gate: assert property (gp(second_dma_clk_run, 4)) else $error("dma2 run");
  chk_dma3_gate: assert property (gp(third_dma_clk_run, 5)) else $error("dma3 run");
  chk_analog_gate: assert property (wr |-> ##2 analog_register_clk_run == !(&$past(an, 2)))
    else $error("analog run");
  chk_analog_keep: assert property (converter_clk_run |-> analog_register_clk_run) else $error("analog off");
  chk_pll_kept: assert property (!usb_controller_clk_run |-> usb_pll_run) else $error("pll off");
  chk_read_zero: assert property (done && avs_read |-> avs_readdata[31:7] == 25'h0) else $error("upper bits");
  cover property (wr ##2 !usb_controller_clk_run);
  cover property (!converter_clk_run && !analog_register_clk_run);
  cover property (!avs_waitrequest && avs_response == `PCGBT_RESP_SLVERR);
endmodule  // pcgbt_chk
bind pcgbt_regs pcgbt_chk u_chk (.*);

// ==== sim/test_peripheral_clock_gate_bank_two.sv ====
// self-checking bench for the gate bank two registers
`include "pcgbt_defines.vh"
module test_peripheral_clock_gate_bank_two;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, avs_read = 0, avs_write = 0, usb_stop_ack = 0, fl = 0;
  logic [15:0] avs_address = 16'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic [1:0] avs_response;
  logic avs_waitrequest, usb_pll_run, display_controller_clk_run, converter_clk_run;
  logic usb_controller_clk_run, first_dma_clk_run, second_dma_clk_run, third_dma_clk_run;
  logic analog_register_clk_run;
  logic [6:0] g = 7'h0;
  logic [33:0] exp_q[$];
  logic [31:0] pat[9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h42, 32'hFFFFFFFF};
  int mismatches = 0, comparisons = 0;
  pcgbt_regs DUT (.*);
  always #12.5 clock = ~clock;
  task wrap_up;
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [33:0] seen, input logic [33:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] readback expected %h seen %h", want, seen);
    end
  endtask
  // one request; the model follows only once the bus took it
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w && a == `PCGBT_GATE_ADDR && be[0]) begin
      if (!g[2] && d[2] && !usb_stop_ack) fl = 1'b1;
      g = d[6:0];
    end
    if (w && a == `PCGBT_STAT_ADDR && be[1] && d[8]) fl = 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task rd(input logic [15:0] a, input logic [33:0] want);
    exp_q.push_back(want);
    acc(1'b0, a, 32'h0, 4'hF);
  endtask
  function logic [33:0] gv();
    return {27'h0, g};
  endfunction
  function logic [33:0] sv();
    return {25'h0, fl, usb_stop_ack, ~(g[6] & g[1]), ~g[5:0]};
  endfunction
  always @(posedge clock)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) check({avs_response, avs_readdata}, exp_q.pop_front());
  initial begin
    logic [31:0] r;
    void'($urandom(32'h073CCE72));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rd(`PCGBT_GATE_ADDR, gv());
    rd(`PCGBT_STAT_ADDR, sv());
    foreach (pat[i]) begin
      acc(1'b1, `PCGBT_GATE_ADDR, pat[i], 4'h1);
      rd(`PCGBT_GATE_ADDR, gv());
      rd(`PCGBT_STAT_ADDR, sv());
    end
    acc(1'b1, `PCGBT_STAT_ADDR, 32'h100, 4'h2);
    acc(1'b1, `PCGBT_GATE_ADDR, 32'h0, 4'h1);
    usb_stop_ack <= 1'b1;
    repeat (3) @(posedge clock);
    acc(1'b1, `PCGBT_GATE_ADDR, 32'h4, 4'h1);
    rd(`PCGBT_STAT_ADDR, sv());
    acc(1'b1, `PCGBT_GATE_ADDR, 32'h0, 4'h1);
    usb_stop_ack <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      acc(1'b1, `PCGBT_GATE_ADDR, r, r[31:28]);
      rd(`PCGBT_GATE_ADDR, gv());
      rd(`PCGBT_STAT_ADDR, sv());
    end
    acc(1'b1, 16'h7014, 32'hFFFFFFFF, 4'hF);
    rd(16'h7014, {2'h2, 32'h0});
    rd(`PCGBT_GATE_ADDR, gv());
    acc(1'b1, `PCGBT_GATE_ADDR, 32'h7F, 4'h1);
    // second reset mid-run: every gate must clear and every clock run
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    g = 7'h0;
    fl = 1'b0;
    rd(`PCGBT_GATE_ADDR, gv());
    rd(`PCGBT_STAT_ADDR, sv());
    wrap_up();
  end
endmodule  // test_peripheral_clock_gate_bank_two
